// ---- rtl/ffi_defines.svh ----
`ifndef FFI_DEFINES_SVH
`define FFI_DEFINES_SVH
// Register indices on the register port
`define FFI_IDX_IRQ_EN_FAULTS 4'h0
`define FFI_IDX_IRQ_EN_INPUT_PIN_OVERVOLTAGE 4'h1
`define FFI_IDX_LIVE_STATUS 4'h2
`define FFI_IDX_FLAGS_FAULTS 4'h3
`define FFI_IDX_FLAGS_MISC 4'h4
`define FFI_IDX_ADC_VOLTAGE 4'h5
`define FFI_IDX_ADC_CURRENT 4'h6
`define FFI_IDX_ADC_SETUP 4'h7
// Fault bit positions, shared by mask and flag registers
`define FFI_BIT_ATTACH 7
`define FFI_BIT_VBUS_UV 6
`define FFI_BIT_DATALINE_OV 5
`define FFI_BIT_VBUS_ILIM 4
`define FFI_BIT_VBUS_OV 3
`define FFI_BIT_VBUS_SHORT 2
`define FFI_BIT_THERMAL_WARN 1
`define FFI_BIT_THERMAL_SHDN 0
// Status bits
`define FFI_BIT_STAT_ATTACH 7
`define FFI_BIT_STAT_CFG_OK 6
// Misc flag bits
`define FFI_BIT_CFG_REQ 2
`define FFI_BIT_ADC_DONE 1
`define FFI_BIT_INPUT_PIN_OVERVOLTAGE 0
// Setup register bits
`define FFI_BIT_CLEAR_MODE 7
`define FFI_BIT_CONV_START 6
`define FFI_BIT_CONV_IRQ_EN 5
// Reset values
`define FFI_RST_BYTE 8'h00
`endif

// ---- rtl/ffi_pkg.sv ----
package ffi_pkg;
  // Register request from the serial interface engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ffi_req_t;
  // Register read answer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ffi_rsp_t;
  // Converter result
  typedef struct packed {
    logic valid;
    logic [7:0] volt;
    logic [7:0] curr;
  } ffi_adc_t;
  // Conversion sequencer states
  typedef enum logic [1:0] {
    FFI_ADC_IDLE = 2'b01,
    FFI_ADC_BUSY = 2'b10
  } ffi_adc_st_t;
endpackage : ffi_pkg

// ---- rtl/ffi_top.sv ----
// Behaviour
// RULE1: fault mask bit 1 enables its interrupt
// RULE2: mask order attach down to thermal shutdown
// RULE3: second mask bit 0 gates input overvoltage
// RULE4: status bit 7 follows live attach
// RULE5: configured flag low holds converter off
// RULE6: standard variant loads configured flag as 1
// RULE7: fault flags set on event, cleared on read
// RULE8: fault flags use mask bit order
// RULE9: power-on sets config request flag
// RULE10: standard variant never raises config request
// RULE11: conversion done flag set with new results
// RULE12: input overvoltage flag, cleared on read
// RULE13: voltage result byte, reset zero
// RULE14: current result byte, reset zero
// RULE15: conversion start bit self-clears on completion
// RULE16: conversion interrupt needs its enable bit
// RULE17: clear mode selects auto-clear or latched flags
// RULE18: interrupt while any enabled flag set
// RULE19: set beats clearing read
`timescale 1ns/100ps
`default_nettype none
`include "ffi_defines.svh"
module ffi_top import ffi_pkg::*; #(
  parameter bit SPECIAL_ORDER = 1'b0 // Configuration handshake present
) (
  input wire logic ref_clk, // System clock, 125 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire ffi_req_t reg_req, // Register access request
  output ffi_rsp_t reg_rsp, // Register read answer
  input wire logic [7:0] fault_in, // Fault detector levels, mask order
  input wire logic input_pin_overvoltage, // Input pin overvoltage level
  input wire ffi_adc_t adc_res, // Converter result strobe and values
  output logic adc_start, // Conversion request to the converter
  output logic dcdc_permit, // Converter may run
  output logic irq // Interrupt request, active high
);

  // Synchroniser stages for detector pins
  logic [8:0] sync_a; // First stage
  logic [8:0] sync_b; // Second stage, only one read by logic

  // Register state
  // Only the implemented bits of each register are stored
  logic [7:0] irq_enable_faults; // Fault interrupt enables
  logic irq_enable_input_ov; // Input overvoltage interrupt enable
  logic cfg_ok; // Configured flag
  logic [7:0] event_flags_faults; // Sticky fault flags
  logic cfg_req; // Configuration request flag
  logic adc_done; // Conversion complete flag
  logic input_pin_overvoltage_flag; // Input overvoltage flag
  logic [7:0] adc_voltage_result; // Voltage sample
  logic [7:0] adc_current_result; // Current sample
  logic flag_clear_mode; // 1 latched, 0 auto-clear
  logic conversion_irq_enable; // Conversion interrupt enable
  logic por_pending; // High in first cycle after reset
  // Busy state mirrors the start bit that the host reads back
  ffi_adc_st_t adc_st; // Conversion sequencer state

  // Next values
  logic [7:0] next_irq_enable_faults;
  logic next_irq_enable_input_ov;
  logic next_cfg_ok;
  logic [7:0] next_event_flags_faults;
  logic next_cfg_req;
  logic next_adc_done;
  logic next_input_pin_overvoltage_flag;
  logic [7:0] next_adc_voltage_result;
  logic [7:0] next_adc_current_result;
  logic next_flag_clear_mode;
  logic next_conversion_irq_enable;
  ffi_adc_st_t next_adc_st;
  ffi_rsp_t next_reg_rsp;
  logic next_irq;
  logic next_adc_start; // Busy level toward the converter
  logic next_dcdc_permit; // Converter run permit

  // Raw strobes and synchronised levels
  logic wr_hit;
  logic rd_hit;
  logic [7:0] fault_live; // Synchronised fault levels
  logic ov_live; // Synchronised input overvoltage level

  // Register index match for a strobe
  // Used for every write decode and every clearing read
  function automatic logic hit(input logic stb, input logic [3:0] a, input logic [3:0] idx);
    hit = stb && (a == idx);
  endfunction : hit

  // Flag update: set wins, clear by read, auto-clear when source gone
  // In latched mode a flag survives until read; in auto-clear mode it
  // also needs its source still present. A live source always sets it
  // again, so an event that lands on the clearing read is never lost.
  function automatic logic flag_next(input logic cur, input logic src, input logic rd,
                                     input logic latched);
    logic keep;
    keep = cur && !rd && (latched || src); // [RULE17]
    flag_next = keep || src; // [RULE7] [RULE12] [RULE19]
  endfunction : flag_next

  // Two-flop synchroniser on detector pins
  // Detector levels bear no relation to ref_clk; only the second stage
  // feeds logic, which costs two cycles of latency on every fault
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_a <= 9'h000;
      sync_b <= 9'h000;
    end else begin
      sync_a <= {input_pin_overvoltage, fault_in};
      sync_b <= sync_a;
    end
  end

  // Synchronised levels and raw strobes used by the decode below
  assign fault_live = sync_b[7:0];
  assign ov_live = sync_b[8];
  assign wr_hit = reg_req.wr;
  assign rd_hit = reg_req.rd;

  // Next values of the register file, flags and sequencer
  always_comb begin
    next_irq_enable_faults = irq_enable_faults;
    next_irq_enable_input_ov = irq_enable_input_ov;
    next_cfg_ok = cfg_ok;
    next_flag_clear_mode = flag_clear_mode;
    next_conversion_irq_enable = conversion_irq_enable;
    next_adc_voltage_result = adc_voltage_result;
    next_adc_current_result = adc_current_result;
    next_adc_st = adc_st;
    next_adc_done = adc_done;
    // Host writes
    // Only one register can be written per cycle, so a chain suffices
    if (hit(wr_hit, reg_req.addr, `FFI_IDX_IRQ_EN_FAULTS)) begin
      next_irq_enable_faults = reg_req.wdata; // [RULE1] [RULE2]
    end else if (hit(wr_hit, reg_req.addr, `FFI_IDX_IRQ_EN_INPUT_PIN_OVERVOLTAGE)) begin
      next_irq_enable_input_ov = reg_req.wdata[0]; // [RULE3]
    end else if (hit(wr_hit, reg_req.addr, `FFI_IDX_LIVE_STATUS)) begin
      // Only the handshake variant lets the host set the flag
      if (SPECIAL_ORDER) begin
        next_cfg_ok = reg_req.wdata[`FFI_BIT_STAT_CFG_OK]; // [RULE9]
      end
    end else if (hit(wr_hit, reg_req.addr, `FFI_IDX_ADC_SETUP)) begin
      next_flag_clear_mode = reg_req.wdata[`FFI_BIT_CLEAR_MODE]; // [RULE17]
      next_conversion_irq_enable = reg_req.wdata[`FFI_BIT_CONV_IRQ_EN]; // [RULE16]
      // Start request launches a conversion when idle
      // Writing 0 to the start bit never aborts a conversion in flight
      if (reg_req.wdata[`FFI_BIT_CONV_START] && adc_st == FFI_ADC_IDLE) begin
        next_adc_st = FFI_ADC_BUSY; // [RULE15]
      end
    end

    // Conversion sequencer
    // Idle waits for a start, busy waits for one result strobe
    case (adc_st)
      FFI_ADC_IDLE: begin
        // Waiting for a start request
        // A result strobe outside a conversion is ignored
      end
      FFI_ADC_BUSY: begin
        // Capture both results, then flag and drop the start bit
        if (adc_res.valid) begin
          next_adc_voltage_result = adc_res.volt; // [RULE13]
          next_adc_current_result = adc_res.curr; // [RULE14]
          next_adc_st = FFI_ADC_IDLE; // [RULE15]
        end
      end
      default: begin
        next_adc_st = FFI_ADC_IDLE;
      end
    endcase

    // Conversion done flag: cleared on read and on a new start, set wins
    // A new start clears the old flag so a stale result is not reported
    if (hit(rd_hit, reg_req.addr, `FFI_IDX_FLAGS_MISC) || next_adc_st == FFI_ADC_BUSY) begin
      next_adc_done = 1'b0; // [RULE11]
    end
    if (adc_st == FFI_ADC_BUSY && adc_res.valid) begin
      next_adc_done = 1'b1; // [RULE11] [RULE19]
    end
    // Busy level shown to the converter until its result arrives
    next_adc_start = (next_adc_st == FFI_ADC_BUSY); // [RULE15]
  end

  // Event flag next values
  // Every fault bit shares one clear mode and one read strobe
  always_comb begin
    // Fault flags in mask bit order, attach down to thermal shutdown
    for (int i = 0; i < 8; i++) begin
      next_event_flags_faults[i] = flag_next(event_flags_faults[i], fault_live[i],
        hit(rd_hit, reg_req.addr, `FFI_IDX_FLAGS_FAULTS), flag_clear_mode); // [RULE7] [RULE8]
    end
    next_input_pin_overvoltage_flag = flag_next(input_pin_overvoltage_flag, ov_live,
      hit(rd_hit, reg_req.addr, `FFI_IDX_FLAGS_MISC), flag_clear_mode); // [RULE12]
    // Request flag raised after every reset, only on handshake variant
    // The standard variant keeps this flag low for good
    next_cfg_req = (cfg_req && !hit(rd_hit, reg_req.addr, `FFI_IDX_FLAGS_MISC))
                   || (por_pending && SPECIAL_ORDER); // [RULE9] [RULE10] [RULE19]
  end

  // Read answer and interrupt output
  always_comb begin
    next_reg_rsp.valid = rd_hit;
    next_reg_rsp.data = 8'h00;
    // Read data mux
    // Reads have no side effect here; clearing reads act in the flag logic
    // Unimplemented status and misc bits read zero
    if (!rd_hit) begin
      next_reg_rsp.data = 8'h00;
    end else if (reg_req.addr == `FFI_IDX_IRQ_EN_FAULTS) begin
      next_reg_rsp.data = irq_enable_faults;
    end else if (reg_req.addr == `FFI_IDX_IRQ_EN_INPUT_PIN_OVERVOLTAGE) begin
      next_reg_rsp.data = {7'h00, irq_enable_input_ov};
    end else if (reg_req.addr == `FFI_IDX_LIVE_STATUS) begin
      next_reg_rsp.data = {fault_live[`FFI_BIT_ATTACH], cfg_ok, 6'h00}; // [RULE4]
    end else if (reg_req.addr == `FFI_IDX_FLAGS_FAULTS) begin
      next_reg_rsp.data = event_flags_faults; // [RULE8]
    end else if (reg_req.addr == `FFI_IDX_FLAGS_MISC) begin
      next_reg_rsp.data = {5'h00, cfg_req, adc_done, input_pin_overvoltage_flag};
    end else if (reg_req.addr == `FFI_IDX_ADC_VOLTAGE) begin
      next_reg_rsp.data = adc_voltage_result; // [RULE13]
    end else if (reg_req.addr == `FFI_IDX_ADC_CURRENT) begin
      next_reg_rsp.data = adc_current_result; // [RULE14]
    end else if (reg_req.addr == `FFI_IDX_ADC_SETUP) begin
      next_reg_rsp.data = {flag_clear_mode, adc_st == FFI_ADC_BUSY, conversion_irq_enable,
                           5'h00}; // [RULE15]
    end else begin
      next_reg_rsp.data = 8'h00; // Unmapped index reads zero
    end
    // Interrupt follows the next flag state so it lines up with the flags
    // The configuration request flag is not an interrupt source
    next_irq = |(next_event_flags_faults & next_irq_enable_faults) // [RULE1] [RULE18]
               || (next_input_pin_overvoltage_flag && next_irq_enable_input_ov) // [RULE3] [RULE18]
               || (next_adc_done && next_conversion_irq_enable); // [RULE16] [RULE18]
    // Converter permit follows the configured flag
    next_dcdc_permit = next_cfg_ok; // [RULE5]
  end

  // Host-written setup and configuration registers
  // The configured flag reloads on every reset, not only at power-on
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_enable_faults <= `FFI_RST_BYTE; // [RULE1]
      irq_enable_input_ov <= 1'b0; // [RULE3]
      cfg_ok <= !SPECIAL_ORDER; // [RULE6]
      flag_clear_mode <= 1'b0; // Auto-clear after reset
      conversion_irq_enable <= 1'b0; // Conversion interrupt off
      por_pending <= 1'b1; // Marks the power-on cycle
    end else begin
      irq_enable_faults <= next_irq_enable_faults;
      irq_enable_input_ov <= next_irq_enable_input_ov;
      cfg_ok <= next_cfg_ok;
      flag_clear_mode <= next_flag_clear_mode;
      conversion_irq_enable <= next_conversion_irq_enable;
      por_pending <= 1'b0; // One cycle high after each reset
    end
  end

  // Event flags
  // Flags start clear; a fault still present sets them again
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      event_flags_faults <= `FFI_RST_BYTE; // [RULE8]
      cfg_req <= 1'b0; // Raised after release on the handshake variant
      input_pin_overvoltage_flag <= 1'b0; // No input overvoltage seen
    end else begin
      event_flags_faults <= next_event_flags_faults;
      cfg_req <= next_cfg_req;
      input_pin_overvoltage_flag <= next_input_pin_overvoltage_flag;
    end
  end

  // Conversion sequencer and results
  // Results are kept until the next completed conversion
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      adc_st <= FFI_ADC_IDLE; // Idle after reset
      adc_done <= 1'b0; // No conversion complete
      adc_voltage_result <= `FFI_RST_BYTE; // [RULE13]
      adc_current_result <= `FFI_RST_BYTE; // [RULE14]
      adc_start <= 1'b0; // No conversion requested
    end else begin
      adc_st <= next_adc_st;
      adc_done <= next_adc_done;
      adc_voltage_result <= next_adc_voltage_result;
      adc_current_result <= next_adc_current_result;
      adc_start <= next_adc_start; // [RULE15]
    end
  end

  // Host answer, interrupt and converter permit
  // Each of these outputs comes straight from its own flop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rsp <= '0; // No answer during reset
      irq <= 1'b0; // Interrupt quiet
      dcdc_permit <= 1'b0; // Converter held off in reset
    end else begin
      reg_rsp <= next_reg_rsp;
      irq <= next_irq;
      dcdc_permit <= next_dcdc_permit; // [RULE5]
    end
  end

endmodule : ffi_top
`default_nettype wire

// ---- dv/ffi_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
// Port-level timing checks of the flag block
module ffi_props import ffi_pkg::*; #(
  parameter bit SPECIAL_ORDER = 1'b0 // Handshake variant
) (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Sync reset
  input wire ffi_req_t reg_req, // Register request
  input wire ffi_rsp_t reg_rsp, // Register answer
  input wire logic [7:0] fault_in, // Fault levels
  input wire logic input_pin_overvoltage, // Input pin level
  input wire ffi_adc_t adc_res, // Converter result
  input wire logic adc_start, // Conversion busy
  input wire logic dcdc_permit, // Converter permit
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  rsp_after_rd_a: assert property (reg_req.rd |=> reg_rsp.valid)
    else $error("read answer missing");
  rsp_no_spurious_a: assert property (!reg_req.rd |=> !reg_rsp.valid)
    else $error("answer without read");
  rsp_idle_zero_a: assert property (!reg_rsp.valid |-> reg_rsp.data == 8'h00)
    else $error("answer data not zero while idle");
  unmapped_zero_a: assert property (reg_req.rd && reg_req.addr[3] |=> reg_rsp.data == 8'h00)
    else $error("unmapped index read not zero");
  // Sync stages must have been out of reset for the attach sample to count
  attach_live_a: assert property (reg_req.rd && reg_req.addr == 4'h2 &&
    $stable(fault_in[7]) && fault_in[7] == $past(fault_in[7], 2) && !$past(rst) &&
    !$past(rst, 2) |=> reg_rsp.data[7] == $past(fault_in[7]))
    else $error("status attach bit not live");
  permit_std_a: assert property (!SPECIAL_ORDER && !$past(rst) |-> dcdc_permit)
    else $error("converter not permitted on standard variant");
  start_take_a: assert property (reg_req.wr && reg_req.addr == 4'h7 &&
    reg_req.wdata[6] && !adc_start |=> adc_start)
    else $error("conversion not started");
  start_hold_a: assert property (adc_start && !adc_res.valid |=> adc_start)
    else $error("start bit dropped early");
  start_clear_a: assert property (adc_start && adc_res.valid |=> !adc_start)
    else $error("start bit not cleared on completion");
  reset_quiet_a: assert property ($past(rst) |-> !irq && !adc_start && !reg_rsp.valid)
    else $error("outputs active out of reset");
endmodule : ffi_props
bind ffi_top ffi_props #(.SPECIAL_ORDER(SPECIAL_ORDER)) u_props (.ref_clk(ref_clk), .rst(rst),
  .reg_req(reg_req), .reg_rsp(reg_rsp), .fault_in(fault_in),
  .input_pin_overvoltage(input_pin_overvoltage), .adc_res(adc_res), .adc_start(adc_start),
  .dcdc_permit(dcdc_permit), .irq(irq));
`default_nettype wire

// ---- dv/ffi_adc_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Converter model: answers a start after LAT+1 cycles with one result pulse
module ffi_adc_model import ffi_pkg::*; #(
  parameter int LAT = 5, // Conversion time in cycles
  parameter logic [7:0] VOLT = 8'h9c, // Voltage sample
  parameter logic [7:0] CURR = 8'h37 // Current sample
) (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic adc_start, // Conversion request
  output ffi_adc_t adc_res // Result strobe and values
);
  int cnt; // Cycles into the conversion
  // Stale values are inverted outside the strobe so they cannot pass by chance
  always @(posedge ref_clk) begin
    if (rst || !adc_start || adc_res.valid) begin
      cnt <= 0;
      adc_res <= '{1'b0, ~VOLT, ~CURR};
    end else begin
      cnt <= cnt + 1;
      adc_res <= (cnt == LAT) ? '{1'b1, VOLT, CURR} : '{1'b0, ~VOLT, ~CURR};
    end
  end
endmodule : ffi_adc_model
`default_nettype wire

// ---- dv/ffi_top_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the flag and readback block
module ffi_top_tb_top import ffi_pkg::*; ;
  typedef struct packed {logic w; logic [3:0] a; logic [7:0] d; logic [7:0] e;} ffi_row_t;
  localparam logic [7:0] VS = 8'h9c; // Voltage sample
  localparam logic [7:0] CS = 8'h37; // Current sample
  logic ref_clk, rst, inov, adc_start, permit, irq; // Pins
  logic [7:0] fault; // Fault levels
  ffi_req_t req; // Register request
  ffi_rsp_t rsp; // Register answer
  ffi_rsp_t rsp_hs; // Answer of the handshake variant
  logic permit_hs; // Permit of the handshake variant
  ffi_adc_t adc; // Converter result
  int n_mismatch, compares; // Counters
  // Reset values, then writes with read-back
  ffi_row_t rows [13] = '{'{1'b0, 4'h0, 8'h00, 8'h00}, '{1'b0, 4'h1, 8'h00, 8'h00},
    '{1'b0, 4'h2, 8'h00, 8'h40}, '{1'b0, 4'h3, 8'h00, 8'h00}, '{1'b0, 4'h4, 8'h00, 8'h00},
    '{1'b0, 4'h5, 8'h00, 8'h00}, '{1'b0, 4'h6, 8'h00, 8'h00}, '{1'b1, 4'h0, 8'h5a, 8'h5a},
    '{1'b1, 4'h1, 8'h01, 8'h01}, '{1'b1, 4'h2, 8'h00, 8'h40}, '{1'b1, 4'h5, 8'hff, 8'h00},
    '{1'b1, 4'h6, 8'hff, 8'h00}, '{1'b1, 4'h9, 8'hff, 8'h00}};
  ffi_top u_dut (.ref_clk(ref_clk), .rst(rst), .reg_req(req), .reg_rsp(rsp), .fault_in(fault),
    .input_pin_overvoltage(inov), .adc_res(adc), .adc_start(adc_start), .dcdc_permit(permit),
    .irq(irq));
  // Handshake variant sharing the same stimulus
  ffi_top #(.SPECIAL_ORDER(1'b1)) u_dut_hs (.ref_clk(ref_clk), .rst(rst), .reg_req(req),
    .reg_rsp(rsp_hs), .fault_in(fault), .input_pin_overvoltage(inov), .adc_res(adc),
    .adc_start(), .dcdc_permit(permit_hs), .irq());
  ffi_adc_model #(.VOLT(VS), .CURR(CS)) u_adc (.ref_clk(ref_clk), .rst(rst),
    .adc_start(adc_start), .adc_res(adc));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic wrap_up();
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  // One register access; a read is checked in the cycle its answer stands
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
    cyc(1);
    req = '{~w, w, a, d};
    cyc(1);
    req = '0;
    if (!w) chk({rsp.valid, rsp.data[6:0]}, {1'b1, e[6:0]});
    if (!w) chk({7'h00, rsp.data[7]}, {7'h00, e[7]});
  endtask : acc
  // Source pulse of two cycles, then time for sync and flag to settle
  task automatic pulse(input logic [7:0] f, input logic o);
    fault = f;
    inov = o;
    cyc(2);
    fault = 8'h00;
    inov = 1'b0;
    cyc(4);
  endtask : pulse
  initial begin
    int i;
    rst = 1'b1; req = '0; fault = 8'h00; inov = 1'b0; n_mismatch = 0; compares = 0;
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    acc(1'b0, 4'h4, 8'h00, 8'h00);
    chk(rsp_hs.data, 8'h04);
    chk({7'h00, permit_hs}, 8'h00);
    acc(1'b1, 4'h2, 8'h40, 8'h00);
    chk({7'h00, permit_hs}, 8'h01);
    acc(1'b0, 4'h2, 8'h00, 8'h40);
    chk(rsp_hs.data, 8'h40);
    acc(1'b0, 4'h4, 8'h00, 8'h00);
    chk(rsp_hs.data, 8'h00);
    foreach (rows[k]) begin
      acc(rows[k].w, rows[k].a, rows[k].d, rows[k].e);
      if (rows[k].w) acc(1'b0, rows[k].a, 8'h00, rows[k].e);
    end
    chk({7'h00, permit}, 8'h01);
    chk({7'h00, permit_hs}, 8'h00);
    acc(1'b1, 4'h7, 8'h80, 8'h00);
    pulse(8'h01, 1'b0);
    chk({7'h00, irq}, 8'h00);
    pulse(8'h08, 1'b0);
    chk({7'h00, irq}, 8'h01);
    acc(1'b0, 4'h3, 8'h00, 8'h09);
    chk({7'h00, irq}, 8'h00);
    acc(1'b0, 4'h3, 8'h00, 8'h00);
    fault = 8'h80;
    cyc(4);
    acc(1'b0, 4'h2, 8'h00, 8'hc0);
    acc(1'b0, 4'h3, 8'h00, 8'h80);
    acc(1'b0, 4'h3, 8'h00, 8'h80);
    fault = 8'h00;
    cyc(4);
    acc(1'b0, 4'h2, 8'h00, 8'h40);
    acc(1'b0, 4'h3, 8'h00, 8'h80);
    acc(1'b0, 4'h3, 8'h00, 8'h00);
    pulse(8'h00, 1'b1);
    chk({7'h00, irq}, 8'h01);
    acc(1'b0, 4'h4, 8'h00, 8'h01);
    acc(1'b0, 4'h4, 8'h00, 8'h00);
    acc(1'b1, 4'h7, 8'he0, 8'h00);
    chk({7'h00, adc_start}, 8'h01);
    acc(1'b0, 4'h7, 8'h00, 8'he0);
    for (i = 0; i < 50 && adc_start !== 1'b0; i++) cyc(1);
    if (i == 50) begin
      n_mismatch++;
      wrap_up();
    end
    chk({7'h00, irq}, 8'h01);
    acc(1'b0, 4'h7, 8'h00, 8'ha0);
    acc(1'b0, 4'h5, 8'h00, VS);
    acc(1'b0, 4'h6, 8'h00, CS);
    acc(1'b0, 4'h4, 8'h00, 8'h02);
    acc(1'b0, 4'h4, 8'h00, 8'h00);
    acc(1'b1, 4'h7, 8'h00, 8'h00);
    fault = 8'h08;
    cyc(4);
    chk({7'h00, irq}, 8'h01);
    fault = 8'h00;
    cyc(4);
    chk({7'h00, irq}, 8'h00);
    pulse(8'h08, 1'b0);
    acc(1'b0, 4'h3, 8'h00, 8'h00);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    acc(1'b0, 4'h0, 8'h00, 8'h00);
    chk({7'h00, permit}, 8'h01);
    acc(1'b0, 4'h4, 8'h00, 8'h00);
    chk(rsp_hs.data, 8'h04);
    wrap_up();
  end
endmodule : ffi_top_tb_top
`default_nettype wire
